//--- logic/irpe_pkg.sv
// Package of constants and carrier types for the infrared pulse encoder/decoder
package irpe_pkg;
  localparam int          IRPE_DATA_W      = 1;
  localparam int          IRPE_FIFO_DEPTH  = 32;
  localparam logic [3:0]  IRPE_BIT_TICKS   = 4'hF;   // Baud ticks per bit, minus one
  localparam logic [3:0]  IRPE_PULSE_TICKS = 4'h3;   // Three sixteenths of a bit
  localparam logic [3:0]  IRPE_SAMPLE_TICK = 4'h8;   // Centre of the bit period
  localparam logic [4:0]  IRPE_WIN_LATE    = 5'h08;  // Window closes eight ticks after the expected pulse
  localparam logic [4:0]  IRPE_WIN_EARLY   = 5'h0C;  // Window opens this many ticks into the bit
  localparam logic        IRPE_IDLE_LINE   = 1'b1;

  typedef enum logic [1:0] {
    IRPE_RX_IDLE  = 2'b00,
    IRPE_RX_TRACK = 2'b01
  } irpe_rx_state_t;

  typedef enum logic [1:0] {
    IRPE_TX_IDLE  = 2'b00,
    IRPE_TX_BIT   = 2'b01
  } irpe_tx_state_t;

  typedef struct packed {
    logic bit_val;
  } irpe_bit_t;
endpackage : irpe_pkg

//--- logic/irpe_top.sv
// Infrared pulse encoder/decoder with transmit bit FIFO, between a UART and a transceiver
// How it works
// - Encode UART transmit bits into infrared pulses
// - Decode received pulses into bits for UART
// - Detection window ends eight ticks after pulse
// - No pulse in window: one, go idle
// - A falling edge in idle or in the window clears the tick counter
// - Resync never shifts bits given to UART
// - Enable input gates the whole function
`timescale 1ns/10ps

module irpe_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } irpe_fifo_st_t;
  irpe_fifo_st_t s_q;
  irpe_fifo_st_t s_d;
  logic          push;
  logic          pop;

  // Ready is a flop that already tells whether a slot is free at the coming edge
  assign o_ready = s_q.rdy;
  assign o_valid = (s_q.cnt != '0);
  assign o_data  = s_q.mem[s_q.rd];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = i_data;
      s_d.wr          = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    s_d.rdy = (s_d.cnt != DEPTH[AW:0]);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : irpe_fifo

// Encoder: one bit per sixteen baud ticks, a zero lights the LED briefly
module irpe_enc
  import irpe_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_enable,
  input  wire logic i_baud_tick,
  input  wire logic i_bit_valid,
  input  wire logic i_bit,
  output logic      o_bit_take,
  output logic      o_led
);
  typedef struct packed {
    irpe_tx_state_t st;
    logic [3:0]     cnt;
    logic           led;
  } irpe_enc_st_t;

  irpe_enc_st_t s_q;
  irpe_enc_st_t s_d;

  // A bit leaves the queue only on a tick, so every bit spans whole ticks
  assign o_bit_take = i_enable && i_baud_tick && (s_q.st == IRPE_TX_IDLE);
  assign o_led      = s_q.led;

  always_comb begin
    s_d = s_q;
    if (!i_enable) begin
      s_d.st  = IRPE_TX_IDLE;
      s_d.cnt = 4'h0;
      s_d.led = 1'b0;
    end else if (i_baud_tick) begin
      unique case (s_q.st)
        IRPE_TX_IDLE: begin
          if (i_bit_valid) begin
            s_d.st  = IRPE_TX_BIT;
            s_d.cnt = 4'h0;
            s_d.led = !i_bit;
          end else begin
            s_d.led = 1'b0;
          end
        end
        IRPE_TX_BIT: begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt + 4'h1 == IRPE_PULSE_TICKS) begin
            s_d.led = 1'b0;
          end
          // Last tick of the bit; the next tick fetches the following bit
          if (s_q.cnt == IRPE_BIT_TICKS - 4'h1) begin
            s_d.st = IRPE_TX_IDLE;
          end
        end
        default: begin
          s_d.st  = IRPE_TX_IDLE;
          s_d.led = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : irpe_enc

// Decoder: a low pulse on the line marks a zero bit
module irpe_dec
  import irpe_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_enable,
  input  wire logic i_baud_tick,
  input  wire logic i_ir_rx,
  output logic      o_rx_bit
);
  typedef struct packed {
    irpe_rx_state_t st;
    logic [4:0]     cnt;
    logic           prev;
    logic           seen;
    logic           bit_val;
  } irpe_dec_st_t;

  // Last tick of the window, eight ticks past the expected next pulse
  localparam logic [4:0]   DEC_WIN_END = 5'h10 + IRPE_WIN_LATE - 5'h01;
  // Previous level resets to idle so release of reset gives no false edge
  localparam irpe_dec_st_t DEC_RST     = '{st:      IRPE_RX_IDLE,
                                           cnt:     5'h00,
                                           prev:    IRPE_IDLE_LINE,
                                           seen:    1'b0,
                                           bit_val: IRPE_IDLE_LINE};

  irpe_dec_st_t s_q;
  irpe_dec_st_t s_d;
  logic         fall;

  // Input taken as synchronous; edge seen against last registered level
  assign fall     = s_q.prev && !i_ir_rx;
  assign o_rx_bit = s_q.bit_val;

  always_comb begin
    s_d      = s_q;
    s_d.prev = i_ir_rx;
    if (!i_enable) begin
      s_d.st      = IRPE_RX_IDLE;
      s_d.cnt     = 5'h00;
      s_d.seen    = 1'b0;
      s_d.bit_val = IRPE_IDLE_LINE;
    end else begin
      unique case (s_q.st)
        IRPE_RX_IDLE: begin
          if (fall) begin
            s_d.st   = IRPE_RX_TRACK;
            s_d.cnt  = 5'h00;
            s_d.seen = 1'b1;
          end
        end
        IRPE_RX_TRACK: begin
          // Falls outside the window are noise and leave the timing alone
          if (fall && (s_q.cnt >= IRPE_WIN_EARLY)) begin
            // Counter realigns only; the bit already given out is untouched
            s_d.cnt  = 5'h00;
            s_d.seen = 1'b1;
          end else if (i_baud_tick) begin
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == {1'b0, IRPE_SAMPLE_TICK}) begin
              s_d.bit_val = !s_q.seen;
              s_d.seen    = 1'b0;
            end
            if (s_q.cnt == DEC_WIN_END) begin
              // No pulse by the window end: the bit is a one
              s_d.st      = IRPE_RX_IDLE;
              s_d.bit_val = IRPE_IDLE_LINE;
            end
          end
        end
        default: begin
          s_d.st      = IRPE_RX_IDLE;
          s_d.bit_val = IRPE_IDLE_LINE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s_q <= DEC_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : irpe_dec

module irpe_top
  import irpe_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_infrared_function_enable,
  input  wire logic i_baud_tick,
  input  wire logic i_uart_tx_bit,
  input  wire logic i_uart_tx_valid,
  output logic      o_uart_tx_ready,
  input  wire logic i_ir_rx,
  output logic      o_ir_tx,
  output logic      o_uart_rx_bit
);
  irpe_bit_t fifo_out;
  irpe_bit_t fifo_in;
  logic      fifo_valid;
  logic      fifo_take;
  logic      fifo_rstn;

  assign fifo_in.bit_val = i_uart_tx_bit;

  // Disabling flushes queued bits, so nothing stale is sent on re-enable
  assign fifo_rstn = i_rstn && i_infrared_function_enable;

  // Back-pressure reaches the UART: it only shifts a bit when a slot is free
  irpe_fifo #(
    .WIDTH (IRPE_DATA_W),
    .DEPTH (IRPE_FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rstn     (fifo_rstn),
    .i_data     (fifo_in),
    .i_valid    (i_uart_tx_valid && i_infrared_function_enable),
    .o_ready    (o_uart_tx_ready),
    .o_data     (fifo_out),
    .o_valid    (fifo_valid),
    .i_ready    (fifo_take)
  );

  irpe_enc u_enc (
    .i_core_clk  (i_core_clk),
    .i_rstn      (i_rstn),
    .i_enable    (i_infrared_function_enable),
    .i_baud_tick (i_baud_tick),
    .i_bit_valid (fifo_valid),
    .i_bit       (fifo_out.bit_val),
    .o_bit_take  (fifo_take),
    .o_led       (o_ir_tx)
  );

  irpe_dec u_dec (
    .i_core_clk  (i_core_clk),
    .i_rstn      (i_rstn),
    .i_enable    (i_infrared_function_enable),
    .i_baud_tick (i_baud_tick),
    .i_ir_rx     (i_ir_rx),
    .o_rx_bit    (o_uart_rx_bit)
  );
endmodule : irpe_top

//--- verif/irpe_sva.sv
// Port checks for the infrared pulse endec
`timescale 1ns/10ps
module irpe_sva (
  input logic i_core_clk,
  input logic i_rstn,
  input logic i_infrared_function_enable,
  input logic i_baud_tick,
  input logic i_uart_tx_bit,
  input logic i_uart_tx_valid,
  input logic o_uart_tx_ready,
  input logic i_ir_rx,
  input logic o_ir_tx,
  input logic o_uart_rx_bit
);
  wire e = i_infrared_function_enable, t = i_baud_tick;
  int pw_q, gp_q, id_q;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_core_clk) begin
    pw_q <= o_ir_tx ? pw_q + int'(t) : 0;
    gp_q <= !i_rstn ? 99 : $rose(o_ir_tx) ? 0 : gp_q + int'(t);
    id_q <= !(i_rstn && i_ir_rx) ? 0 : id_q + int'(t);
  end
  a_off_led: assert property (!e [*2] |-> !o_ir_tx) else $error("led on while off");
  a_off_rx: assert property (!e [*2] |-> o_uart_rx_bit) else $error("rx zero while off");
  a_off_ready: assert property (!e [*2] |-> !o_uart_tx_ready) else $error("ready while off");
  a_pulse_start: assert property ($rose(o_ir_tx) |-> $past(t) && $past(e)) else $error("pulse off tick");
  a_pulse_width: assert property ($fell(o_ir_tx) && $past(e) |-> pw_q == 3) else $error("pulse width");
  a_bit_spacing: assert property ($rose(o_ir_tx) |-> gp_q > 15) else $error("bits too close");
  a_idle_one: assert property (id_q > 25 |-> o_uart_rx_bit) else $error("zero with no pulse");
  a_zero_pulse: assert property (!o_uart_rx_bit |-> id_q < 23) else $error("zero held too long");
endmodule : irpe_sva

//--- verif/irpe_xcvr.sv
// Transceiver model: LED looped to rx after a chosen lag
`timescale 1ns/10ps
module irpe_xcvr (
  input  logic       i_clk,
  input  logic       i_led,
  input  logic [1:0] i_lag,
  output logic       o_rxd
);
  logic [3:0] sh_q = 4'h0;
  always_ff @(posedge i_clk) sh_q <= {sh_q[2:0], i_led};
  assign o_rxd = !sh_q[i_lag];
endmodule : irpe_xcvr

//--- verif/tb_infrared_pulse_endec.sv
// Bench: loopback traffic, FIFO refusal, rx jitter, disable
`timescale 1ns/10ps
module tb_infrared_pulse_endec;
  logic clk = 0, rstn = 0, en = 0, tk = 0, tg = 0, jit = 0, txb = 1, tv = 0, b;
  logic rdy, ir, rx, rxb;
  logic pb;
  int n_mismatch = 0, compares = 0, nz, zs, np, acc, nr, cyc = 0, lag = 0;
  irpe_top DUT (.i_core_clk(clk), .i_rstn(rstn), .i_infrared_function_enable(en), .i_baud_tick(tk),
    .i_uart_tx_bit(txb), .i_uart_tx_valid(tv), .o_uart_tx_ready(rdy),
    .i_ir_rx(rx), .o_ir_tx(ir), .o_uart_rx_bit(rxb));
  irpe_xcvr XCVR (.i_clk(clk), .i_led(ir), .i_lag(lag[1:0]), .o_rxd(rx));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tk <= tg && cyc % 4 == 3;
    nz += int'(tk && !rxb);
    np += int'($rose(ir));
    if ($rose(ir) && jit) lag <= $urandom % 4;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %0d exp %0d", $time, g, e);
    end
  endtask : chk
  task automatic run(input logic j);
    jit = j;
    tg <= 0;
    {nz, zs, np, acc, nr} = 0;
    pb = 1;
    for (int i = 0; i < 33; i++) begin
      b = (i > 30) ? 1'b0 : 1'($urandom);
      txb <= b;
      tv <= 1;
      @(negedge clk);
      acc += int'(rdy);
      zs += int'(rdy && !b);
      nr += int'(rdy && !b && pb);
      if (rdy) pb = b;
      @(posedge clk);
    end
    tv <= 0;
    chk(16'(acc), 16'h0020);
    tg <= 1;
    repeat (2300) @(posedge clk);
    chk(16'(np), 16'(zs));
    chk(16'((nz + nr + 8) / 16), 16'(zs));
    $display("Test jitter=%0d done", j);
  endtask : run
  task automatic results(input int fail);
    n_mismatch += fail;
    $display("%0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial #100000 results(1);
  initial begin
    void'($urandom(80344));
    repeat (10) @(posedge clk);
    rstn <= 1;
    en <= 1;
    run(0);
    run(1);
    en <= 0;
    txb <= 0;
    tv <= 1;
    repeat (3) @(posedge clk);
    chk(16'({rdy, ir, rxb}), 16'h0001);
    $display("Test disable done");
    results(0);
  end
endmodule : tb_infrared_pulse_endec
bind irpe_top irpe_sva SVA (.*);
